// *** rtl/mirq_top.sv ***
// Purpose: event status, interrupt mask and phy maintenance registers
// Assumes: event inputs are one-cycle strobes synchronous to clk_sys_i
// Notes:   classic wishbone slave, one wait state on every access
`timescale 1ns/1ps
`default_nettype none
module mirq_top #(
	parameter int unsigned QUANTUM_CYCLES = mirq_pkg::QUANTUM_CYCLES,
	parameter int unsigned MDC_HALF       = mirq_pkg::MDC_HALF_CYCLES
)(
	// system
	input  wire logic        clk_sys_i,
	input  wire logic        reset_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic             wb_ack_o,
	output logic [31:0]      wb_dat_o,
	// transmit events
	input  wire logic        tx_late_i,
	input  wire logic        tx_bus_err_i,
	input  wire logic        tx_used_mid_i,
	input  wire logic        tx_queue_ptr_wr_i,
	input  wire logic        retry_limit_i,
	input  wire logic        tx_bufs_exhausted_i,
	input  wire logic        tx_frame_done_i,
	input  wire logic        tx_used_desc_i,
	// receive and dma events
	input  wire logic        rx_overrun_set_i,
	input  wire logic        dma_bus_err_i,
	input  wire logic        rx_frame_stored_i,
	input  wire logic        rx_used_desc_i,
	// pause frames
	input  wire logic        pause_frame_i,
	input  wire logic [15:0] pause_frame_val_i,
	// management pins
	input  wire logic        mgmt_data_i,
	output logic             mgmt_clk_o,
	output logic             mgmt_data_o,
	output logic             mgmt_data_oe_o,
	// interrupt
	output logic             irq_o
);
	if (QUANTUM_CYCLES < 1 || MDC_HALF < 1) begin
		$error("timing parameters must be at least one cycle");
	end

	mirq_if lnk();

	logic [31:0] status_reg;
	logic [31:0] status_next;
	logic [31:0] mask_reg;
	logic [31:0] man_reg;
	logic [31:0] ev;
	logic [31:0] rdata;
	logic [31:0] en_bits;
	logic [31:0] dis_bits;
	logic [31:0] pause_wr_val;
	logic        start_reg;
	logic        req;
	logic        wr_stb;
	logic        rd_stb;
	logic        frame_ok;

	function automatic logic [31:0] be_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  sel
	);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old_v & ~m) | (new_v & m);
	endfunction

	function automatic logic hit(
		input logic [7:0] adr,
		input logic [7:0] off
	);
		return adr == off;
	endfunction

	// bus handshake
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_stb = req && wb_we_i;
	assign rd_stb = req && !wb_we_i;

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			wb_dat_o <= '0;
		end else if (rd_stb) begin
			wb_dat_o <= rdata;
		end
	end

	always_comb begin
		rdata = '0;
		unique case (wb_adr_i)
			mirq_pkg::OFF_STATUS: rdata = status_reg;
			mirq_pkg::OFF_MASK: rdata = mask_reg & mirq_pkg::SRC_BITS;
			mirq_pkg::OFF_MAN: rdata = man_reg;
			mirq_pkg::OFF_PAUSE: rdata = {16'h0, lnk.p_count};
			default: rdata = '0;
		endcase
	end

	// event collection
	always_comb begin
		ev = '0;
		ev[mirq_pkg::B_TX_UNDER] = tx_late_i | tx_bus_err_i | tx_used_mid_i | tx_queue_ptr_wr_i;
		ev[mirq_pkg::B_TX_EXHAUST] = tx_bufs_exhausted_i;
		ev[mirq_pkg::B_TX_DONE] = tx_frame_done_i;
		ev[mirq_pkg::B_RX_OVER] = rx_overrun_set_i;
		ev[mirq_pkg::B_BUS_ERR] = dma_bus_err_i;
		ev[mirq_pkg::B_PAUSE_RX] = pause_frame_i;
		ev[mirq_pkg::B_PAUSE_ZERO] = lnk.p_expired;
		ev[mirq_pkg::B_MGMT_DONE] = lnk.done;
		ev[mirq_pkg::B_RX_USED] = rx_used_desc_i;
		ev[mirq_pkg::B_TX_USED] = tx_used_desc_i;
		ev[mirq_pkg::B_RX_DONE] = rx_frame_stored_i;
		ev[mirq_pkg::B_RETRY] = retry_limit_i;
	end

	// status flags, read clears, new event wins
	always_comb begin
		status_next = status_reg;
		if (rd_stb && hit(wb_adr_i, mirq_pkg::OFF_STATUS)) begin
			status_next = '0;
		end
		status_next = status_next | (ev & mirq_pkg::SRC_BITS);
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			status_reg <= mirq_pkg::STATUS_RST;
		end else begin
			status_reg <= status_next;
		end
	end

	// interrupt mask, one means masked
	always_comb begin
		en_bits = '0;
		dis_bits = '0;
		if (wr_stb && hit(wb_adr_i, mirq_pkg::OFF_EN)) begin
			en_bits = be_merge('0, wb_dat_i, wb_sel_i) & mirq_pkg::SRC_BITS;
		end
		if (wr_stb && hit(wb_adr_i, mirq_pkg::OFF_DIS)) begin
			dis_bits = be_merge('0, wb_dat_i, wb_sel_i) & mirq_pkg::SRC_BITS;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			mask_reg <= mirq_pkg::MASK_RST;
		end else begin
			mask_reg <= (mask_reg & ~en_bits) | dis_bits;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(status_reg & ~mask_reg & mirq_pkg::SRC_BITS);
		end
	end

	// phy maintenance register
	always_comb begin
		logic [31:0] nv;
		nv = be_merge(man_reg, wb_dat_i, wb_sel_i);
		frame_ok = (nv[mirq_pkg::MAN_SOF_LO +: 2] == mirq_pkg::SOF_VALID)
			&& (nv[mirq_pkg::MAN_OP_LO +: 2] == mirq_pkg::OP_READ
			|| nv[mirq_pkg::MAN_OP_LO +: 2] == mirq_pkg::OP_WRITE);
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			man_reg <= mirq_pkg::MAN_RST;
			start_reg <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			if (wr_stb && hit(wb_adr_i, mirq_pkg::OFF_MAN) && !lnk.busy && !start_reg) begin
				man_reg <= be_merge(man_reg, wb_dat_i, wb_sel_i);
				start_reg <= frame_ok;
			end else if (lnk.done && lnk.read_op) begin
				man_reg[mirq_pkg::MAN_DATA_W-1:0] <= lnk.rd_data;
			end
		end
	end

	assign lnk.start = start_reg;
	assign lnk.frame = man_reg;
	assign lnk.read_op = (man_reg[mirq_pkg::MAN_OP_LO +: 2] == mirq_pkg::OP_READ);

	// pause time counter load, software write wins
	assign pause_wr_val = be_merge({16'h0, lnk.p_count}, wb_dat_i, wb_sel_i);
	assign lnk.p_load = (wr_stb && hit(wb_adr_i, mirq_pkg::OFF_PAUSE)) || pause_frame_i;
	assign lnk.p_val = (wr_stb && hit(wb_adr_i, mirq_pkg::OFF_PAUSE))
		? pause_wr_val[mirq_pkg::PAUSE_W-1:0] : pause_frame_val_i;

	mirq_pause #(
		.QUANTUM   (QUANTUM_CYCLES)
	) u_pause (
		.clk_sys_i (clk_sys_i),
		.reset_i   (reset_i),
		.lnk       (lnk.pause)
	);

	mirq_mgmt #(
		.HALF      (MDC_HALF)
	) u_mgmt (
		.clk_sys_i (clk_sys_i),
		.reset_i   (reset_i),
		.lnk       (lnk.mgmt),
		.mdio_i    (mgmt_data_i),
		.mdc_o     (mgmt_clk_o),
		.mdio_o    (mgmt_data_o),
		.mdio_oe_o (mgmt_data_oe_o)
	);
endmodule
`default_nettype wire

// *** shared/mirq_pkg.sv ***
// Purpose: constants shared by the interrupt and management register block
// Assumes: 32-bit classic wishbone, byte addresses in the low 8 bits
// Notes:   event bit positions are common to status, enable, disable and mask
package mirq_pkg;
	localparam int unsigned ADR_W = 8;
	localparam logic [7:0] OFF_STATUS = 8'h24;
	localparam logic [7:0] OFF_EN = 8'h28;
	localparam logic [7:0] OFF_DIS = 8'h2c;
	localparam logic [7:0] OFF_MASK = 8'h30;
	localparam logic [7:0] OFF_MAN = 8'h34;
	localparam logic [7:0] OFF_PAUSE = 8'h38;
	// event bit positions
	localparam int unsigned B_MGMT_DONE = 0;
	localparam int unsigned B_RX_DONE = 1;
	localparam int unsigned B_RX_USED = 2;
	localparam int unsigned B_TX_USED = 3;
	localparam int unsigned B_TX_UNDER = 4;
	localparam int unsigned B_RETRY = 5;
	localparam int unsigned B_TX_EXHAUST = 6;
	localparam int unsigned B_TX_DONE = 7;
	localparam int unsigned B_RX_OVER = 10;
	localparam int unsigned B_BUS_ERR = 11;
	localparam int unsigned B_PAUSE_RX = 12;
	localparam int unsigned B_PAUSE_ZERO = 13;
	localparam logic [31:0] SRC_BITS = 32'h0000_3cff;
	localparam logic [31:0] STATUS_RST = 32'h0000_0000;
	localparam logic [31:0] MASK_RST = SRC_BITS;
	localparam logic [31:0] MAN_RST = 32'h0000_0000;
	// maintenance fields
	localparam int unsigned MAN_SOF_LO = 30;
	localparam int unsigned MAN_OP_LO = 28;
	localparam int unsigned MAN_DATA_W = 16;
	localparam logic [1:0] SOF_VALID = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	// management frame shape
	localparam logic [5:0] IDX_LAST = 6'h3f;
	localparam logic [5:0] IDX_TA = 6'h2e;
	localparam logic [5:0] IDX_DATA = 6'h30;
	localparam logic [31:0] PREAMBLE = 32'hffff_ffff;
	// timing
	localparam int unsigned CLK_NS = 100;
	localparam int unsigned BIT_NS = 100;
	localparam int unsigned QUANTUM_BITS = 512;
	localparam int unsigned QUANTUM_CYCLES = QUANTUM_BITS * BIT_NS / CLK_NS;
	localparam int unsigned MDC_HALF_NS = 400;
	localparam int unsigned MDC_HALF_CYCLES = (MDC_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned PAUSE_W = 16;
endpackage

// *** shared/mirq_if.sv ***
// Purpose: carrier between the register block and its two engines
// Assumes: one clock domain
// Notes:   pause group and management group
`timescale 1ns/1ps
`default_nettype none
interface mirq_if;
	logic        start;
	logic [31:0] frame;
	logic        read_op;
	logic        busy;
	logic        done;
	logic [15:0] rd_data;
	logic        p_load;
	logic [15:0] p_val;
	logic [15:0] p_count;
	logic        p_expired;
	modport mgmt(input start, frame, read_op, output busy, done, rd_data);
	modport pause(input p_load, p_val, output p_count, p_expired);
endinterface
`default_nettype wire

// *** rtl/mirq_pause.sv ***
// Purpose: pause time counter, one decrement per quantum
// Assumes: load pulses come from the register block
// Notes:   expiry pulses only on a count from one to zero
`timescale 1ns/1ps
`default_nettype none
module mirq_pause #(
	parameter int unsigned QUANTUM = mirq_pkg::QUANTUM_CYCLES
)(
	// system
	input  wire logic clk_sys_i,
	input  wire logic reset_i,
	// carrier
	mirq_if.pause     lnk
);
	localparam int unsigned DW = $clog2(QUANTUM + 1);
	if (QUANTUM < 1) begin
		$error("quantum must be at least one cycle");
	end
	logic [DW-1:0] div_reg;
	logic          tick;
	assign tick = (div_reg == DW'(QUANTUM - 1));
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			div_reg <= '0;
		end else if (lnk.p_load || lnk.p_count == '0 || tick) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + DW'(1);
		end
	end
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			lnk.p_count <= '0;
			lnk.p_expired <= 1'b0;
		end else begin
			lnk.p_expired <= 1'b0;
			if (lnk.p_load) begin
				lnk.p_count <= lnk.p_val;
			end else if (tick && lnk.p_count != '0) begin
				lnk.p_count <= lnk.p_count - 16'h1;
				lnk.p_expired <= (lnk.p_count == 16'h1);
			end
		end
	end
endmodule
`default_nettype wire

// *** rtl/mirq_mgmt.sv ***
// Purpose: shifts one management frame out to the phy
// Assumes: start only while idle, frame stable while busy
// Notes:   32 preamble ones, then the 32-bit frame msb first
`timescale 1ns/1ps
`default_nettype none
module mirq_mgmt #(
	parameter int unsigned HALF = mirq_pkg::MDC_HALF_CYCLES
)(
	// system
	input  wire logic clk_sys_i,
	input  wire logic reset_i,
	// carrier
	mirq_if.mgmt      lnk,
	// pins
	input  wire logic mdio_i,
	output logic      mdc_o,
	output logic      mdio_o,
	output logic      mdio_oe_o
);
	localparam int unsigned DW = $clog2(HALF + 1);
	if (HALF < 1) begin
		$error("management half period must be at least one cycle");
	end
	typedef enum logic {MG_IDLE, MG_RUN} mirq_mg_t;
	mirq_mg_t      state_reg;
	logic [DW-1:0] div_reg;
	logic [5:0]    idx_reg;
	logic [63:0]   sh_reg;
	logic          rd_reg;
	logic          tick;
	assign tick = (div_reg == DW'(HALF - 1));
	assign lnk.busy = (state_reg != MG_IDLE);
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg <= MG_IDLE;
			div_reg <= '0;
			idx_reg <= '0;
			sh_reg <= '0;
			rd_reg <= 1'b0;
			mdc_o <= 1'b0;
			mdio_o <= 1'b0;
			mdio_oe_o <= 1'b0;
			lnk.done <= 1'b0;
			lnk.rd_data <= '0;
		end else begin
			lnk.done <= 1'b0;
			unique case (state_reg)
				MG_IDLE: begin
					mdc_o <= 1'b0;
					mdio_oe_o <= 1'b0;
					if (lnk.start) begin
						state_reg <= MG_RUN;
						div_reg <= '0;
						idx_reg <= '0;
						sh_reg <= {mirq_pkg::PREAMBLE, lnk.frame};
						rd_reg <= lnk.read_op;
						mdio_o <= 1'b1;
						mdio_oe_o <= 1'b1;
					end
				end
				MG_RUN: begin
					div_reg <= tick ? '0 : div_reg + DW'(1);
					if (tick) begin
						mdc_o <= ~mdc_o;
						if (!mdc_o && rd_reg && idx_reg >= mirq_pkg::IDX_DATA) begin
							lnk.rd_data <= {lnk.rd_data[14:0], mdio_i};
						end
						if (mdc_o && idx_reg == mirq_pkg::IDX_LAST) begin
							state_reg <= MG_IDLE;
							mdio_oe_o <= 1'b0;
							lnk.done <= 1'b1;
						end else if (mdc_o) begin
							idx_reg <= idx_reg + 6'h1;
							sh_reg <= {sh_reg[62:0], 1'b0};
							mdio_o <= sh_reg[62];
							mdio_oe_o <= !(rd_reg && (idx_reg + 6'h1) >= mirq_pkg::IDX_TA);
						end
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// *** dv/mirq_properties.sv ***
// Purpose: port-level checks of the event and maintenance block
// Assumes: one clock, asynchronous active-high reset
// Notes:   bound into mirq_top below the module
`timescale 1ns/1ps
`default_nettype none
module mirq_properties #(
	parameter int unsigned MDC_HALF = 2
)(
	// system
	input wire logic        clk_sys_i,
	input wire logic        reset_i,
	// bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	// management pins
	input wire logic        mgmt_clk_o,
	input wire logic        mgmt_data_o,
	input wire logic        mgmt_data_oe_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	logic       req;
	logic       rd;
	logic [7:0] hi_cnt;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rd = req && !wb_we_i;
	// high-phase length of the management clock
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i)
			hi_cnt <= 8'h00;
		else
			hi_cnt <= mgmt_clk_o ? hi_cnt + 8'h01 : 8'h00;
	end
	sequence s_man_start;
		req && wb_we_i && wb_adr_i == mirq_pkg::OFF_MAN && wb_dat_i[31:30] == mirq_pkg::SOF_VALID
		&& (wb_dat_i[29:28] == mirq_pkg::OP_READ || wb_dat_i[29:28] == mirq_pkg::OP_WRITE)
		&& !mgmt_data_oe_o && !mgmt_clk_o;
	endsequence
	sequence s_preamble;
		(mgmt_data_oe_o && mgmt_data_o) [*8];
	endsequence
	a_ack_next: assert property (req |=> wb_ack_o)
		else $error("no ack one cycle after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	a_dat_hold: assert property (!rd |=> $stable(wb_dat_o))
		else $error("read data changed without read");
	a_wo_reads_zero: assert property (rd && (wb_adr_i == mirq_pkg::OFF_EN ||
		wb_adr_i == mirq_pkg::OFF_DIS || wb_adr_i == 8'h3c) |=> wb_dat_o == 32'h0000_0000)
		else $error("write-only or unmapped read not zero");
	a_frame_start: assert property (s_man_start |=> ##1 s_preamble)
		else $error("frame did not start after maintenance write");
	a_mdc_half: assert property ($fell(mgmt_clk_o) |-> 32'(hi_cnt) == MDC_HALF)
		else $error("management clock high phase wrong");
	a_mdc_bound: assert property (32'(hi_cnt) <= MDC_HALF)
		else $error("management clock high too long");
	a_data_clk_low: assert property (mgmt_data_oe_o && $past(mgmt_data_oe_o)
		&& $changed(mgmt_data_o) |-> !mgmt_clk_o)
		else $error("data changed while management clock high");
endmodule
bind mirq_top mirq_properties #(.MDC_HALF(MDC_HALF)) mirq_properties_i (.clk_sys_i, .reset_i,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .wb_dat_o,
	.mgmt_clk_o, .mgmt_data_o, .mgmt_data_oe_o);
`default_nettype wire

// *** dv/mirq_phy_model.sv ***
// Purpose: behavioural phy on the management line
// Assumes: line pulled up when nobody drives
// Notes:   answers read frames with rd_val_i
`timescale 1ns/1ps
`default_nettype none
module mirq_phy_model (
	input  wire logic        reset_i,
	input  wire logic        mgmt_clk_i,
	input  wire logic        mdio_i,
	input  wire logic [15:0] rd_val_i,
	output logic             phy_oe_o,
	output logic             phy_d_o,
	output logic [31:0]      frame_o,
	output int               frames_o
);
	logic [63:0] sh;
	logic [1:0]  op;
	int          cnt;
	initial begin
		phy_oe_o = 1'b0;
		phy_d_o = 1'b1;
		frame_o = 32'h0000_0000;
		frames_o = 0;
		cnt = 0;
	end
	always @(posedge reset_i) cnt = 0;
	// capture bits on the rising clock, keep the frame
	always @(posedge mgmt_clk_i) begin
		sh = {sh[62:0], mdio_i};
		cnt = cnt + 1;
		if (cnt == 36)
			op = sh[1:0];
		if (cnt == 64) begin
			frame_o = sh[31:0];
			frames_o = frames_o + 1;
			cnt = 0;
			phy_oe_o = 1'b0;
		end
	end
	// answer a read after turnaround
	always @(negedge mgmt_clk_i) begin
		if (op == mirq_pkg::OP_READ && cnt >= 47 && cnt < 64) begin
			phy_oe_o = 1'b1;
			phy_d_o = (cnt == 47) ? 1'b0 : rd_val_i[63 - cnt];
		end
	end
endmodule
`default_nettype wire

// *** dv/mirq_top_test.sv ***
// Purpose: self-checking bench of the event and maintenance block
// Assumes: short quantum and management clock
// Notes:   event rows first, then awkward cases
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("Error at %0t: got %h expected %h", $time, a, e); end end
module mirq_top_test;
	logic        clk_sys_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        req = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic [12:0] ev = 13'h0000;
	logic [15:0] pval = 16'h0000;
	logic        ack;
	logic [31:0] rdat;
	logic        mclk;
	logic        mdo;
	logic        moe;
	logic        irq;
	logic        phy_oe;
	logic        phy_d;
	logic [31:0] frame;
	int          frames;
	int          error_cnt = 0;
	int          checks = 0;
	logic [31:0] q;
	logic [31:0] row_exp [13] = '{32'h10, 32'h10, 32'h10, 32'h10, 32'h20, 32'h40, 32'h80,
		32'h08, 32'h400, 32'h800, 32'h02, 32'h04, 32'h1000};
	wire         mdio = moe ? mdo : (phy_oe ? phy_d : 1'b1);
	initial forever #50 clk_sys_i = ~clk_sys_i;
	mirq_top #(.QUANTUM_CYCLES(4), .MDC_HALF(2)) mirq_top_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat), .tx_late_i(ev[0]), .tx_bus_err_i(ev[1]),
		.tx_used_mid_i(ev[2]), .tx_queue_ptr_wr_i(ev[3]), .retry_limit_i(ev[4]),
		.tx_bufs_exhausted_i(ev[5]), .tx_frame_done_i(ev[6]), .tx_used_desc_i(ev[7]),
		.rx_overrun_set_i(ev[8]), .dma_bus_err_i(ev[9]), .rx_frame_stored_i(ev[10]),
		.rx_used_desc_i(ev[11]), .pause_frame_i(ev[12]), .pause_frame_val_i(pval),
		.mgmt_data_i(mdio), .mgmt_clk_o(mclk), .mgmt_data_o(mdo), .mgmt_data_oe_o(moe), .irq_o(irq));
	mirq_phy_model mirq_phy_model_i (.reset_i(reset_i), .mgmt_clk_i(mclk), .mdio_i(mdio),
		.rd_val_i(16'h5a3c), .phy_oe_o(phy_oe), .phy_d_o(phy_d), .frame_o(frame), .frames_o(frames));
	task end_of_test;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys_i);
		req <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			error_cnt++;
			end_of_test;
		end else begin
			q = rdat;
			req <= 1'b0;
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		`CHK(q, e)
	endtask
	task automatic pulse(input int b);
		@(posedge clk_sys_i);
		ev <= 13'h0001 << b;
		@(posedge clk_sys_i);
		ev <= 13'h0000;
	endtask
	task automatic wait_done;
		int n;
		n = 0;
		do begin
			wb(1'b0, mirq_pkg::OFF_STATUS, 32'h0000_0000);
			n++;
		end while (q[0] !== 1'b1 && n < 200);
		`CHK(q[0], 1'b1)
		if (q[0] !== 1'b1)
			end_of_test;
	endtask
	initial begin
		repeat (16) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		rd(mirq_pkg::OFF_STATUS, 32'h0000_0000);
		rd(mirq_pkg::OFF_MASK, 32'h0000_3cff);
		wb(1'b1, mirq_pkg::OFF_EN, 32'h0000_3cff);
		rd(mirq_pkg::OFF_MASK, 32'h0000_0000);
		rd(mirq_pkg::OFF_EN, 32'h0000_0000);
		rd(8'h3c, 32'h0000_0000);
		for (int i = 0; i < 13; i++) begin
			pulse(i);
			repeat (2) @(posedge clk_sys_i);
			`CHK(irq, 1'b1)
			rd(mirq_pkg::OFF_STATUS, row_exp[i]);
			rd(mirq_pkg::OFF_STATUS, 32'h0000_0000);
			`CHK(irq, 1'b0)
		end
		wb(1'b1, mirq_pkg::OFF_DIS, 32'h0000_0080);
		rd(mirq_pkg::OFF_MASK, 32'h0000_0080);
		pulse(6);
		repeat (2) @(posedge clk_sys_i);
		`CHK(irq, 1'b0)
		rd(mirq_pkg::OFF_STATUS, 32'h0000_0080);
		pval <= 16'h0003;
		pulse(12);
		repeat (30) @(posedge clk_sys_i);
		rd(mirq_pkg::OFF_STATUS, 32'h0000_3000);
		wb(1'b1, mirq_pkg::OFF_PAUSE, 32'h0000_0001);
		repeat (12) @(posedge clk_sys_i);
		rd(mirq_pkg::OFF_STATUS, 32'h0000_2000);
		rd(mirq_pkg::OFF_PAUSE, 32'h0000_0000);
		wb(1'b1, mirq_pkg::OFF_MAN, 32'h52b2_beef);
		wait_done;
		`CHK(frame, 32'h52b2_beef)
		wb(1'b1, mirq_pkg::OFF_MAN, 32'h62b2_0000);
		wait_done;
		rd(mirq_pkg::OFF_MAN, 32'h62b2_5a3c);
		wb(1'b1, mirq_pkg::OFF_MAN, 32'h42b2_1234);
		repeat (300) @(posedge clk_sys_i);
		rd(mirq_pkg::OFF_STATUS, 32'h0000_0000);
		`CHK(frames, 2)
		rd(mirq_pkg::OFF_MAN, 32'h42b2_1234);
		wb(1'b1, mirq_pkg::OFF_MAN, 32'h12b2_0000);
		repeat (300) @(posedge clk_sys_i);
		`CHK(frames, 2)
		reset_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		rd(mirq_pkg::OFF_MASK, 32'h0000_3cff);
		`CHK(irq, 1'b0)
		end_of_test;
	end
endmodule
`default_nettype wire
